// ===== clk_fs_pkg.sv
// Behaviour
// - on external clock failure select fast internal osc at 1 MHz, set fail flag
// - interrupt raised when fail flag and fail interrupt enable both set
// - after fallback stay internal until a changed request write or a sleep clears fail-safe and the switch succeeds
// - fail-safe clears on reset, sleep, or change of request fields
// - switching to external or pll restarts startup timer; keep running on the current source meanwhile
// - fail-safe clears at the request change, before timer expiry and switch; persisting failure re-flags
// - failure detection only after startup timer expired; timer runs after wake and reset
// - external clock input mode skips startup timer
// - request register: source bits 6-4, divider bits 3-0, bit 7 reads zero
// - source request loaded at reset from reset oscillator setting
// - write with reserved source code is discarded entirely
// - switch allow config low makes request register read-only
// - reset divider is 0010 when source is 110, else 0000
// - current register exposes read-only source and divider, reset equal to request
// - source codes 111 ext, 110 fast, 101 slow, 100 secondary, 010 ext pll, 001 fast pll
// - source codes 011 and 000 behave as 110
// - divider codes 0000-1001 divide by 1..512, 1010-1111 reserved
// - switch hold pauses switch with interrupt at ready; hardware clears hold only when the held switch is abandoned
// - secondary osc power bit: 1 high power, 0 low power
// - switch done reads 1 when current equals request, 0 during switch
// - new ready reads 1 only while switching and requested osc ready
// - monitor sample clock is slow internal osc divided by 64
// - latch set by falling ext clock, cleared by rising sample; no low for half-cycle fails
// - on switch completion update current, set switch done, clear new ready
package clk_fs_pkg;
  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [3:0] ADDR_REQ     = 4'h0;
  localparam logic [3:0] ADDR_CUR     = 4'h4;
  localparam logic [3:0] ADDR_HSK     = 4'h8;
  localparam logic [3:0] ADDR_FAIL    = 4'hc;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int SRC_LSB   = 4;
  localparam int HOLD_BIT  = 7;
  localparam int SPWR_BIT  = 6;
  localparam int DONE_BIT  = 4;
  localparam int NRDY_BIT  = 3;
  localparam int FFLAG_BIT = 0;
  localparam int FIE_BIT   = 1;
  localparam int FSAFE_BIT = 2;
  // ----------------------------------------
  // source codes and reset values
  // ----------------------------------------
  localparam logic [2:0] SRC_EXT    = 3'h7;
  localparam logic [2:0] SRC_FAST   = 3'h6;
  localparam logic [2:0] SRC_SLOW   = 3'h5;
  localparam logic [2:0] SRC_SEC    = 3'h4;
  localparam logic [2:0] SRC_RSV3   = 3'h3;
  localparam logic [2:0] SRC_EXTPLL = 3'h2;
  localparam logic [2:0] SRC_FSTPLL = 3'h1;
  localparam logic [2:0] SRC_RSV0   = 3'h0;
  localparam logic [3:0] DIV_FAST_RST = 4'h2;
  localparam logic [3:0] DIV_RST      = 4'h0;
  localparam logic [3:0] DIV_MAX      = 4'h9;
  localparam logic [3:0] DIV_1MHZ     = 4'h2;  // fast osc runs at 4 MHz nominal after reset
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int SAMPLE_DIV   = 64;
  localparam int SAMPLE_HALF  = SAMPLE_DIV / 2;
  localparam int OST_CYCLES   = 1024;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_HOLD = 3'b100
  } sw_state_t;
endpackage : clk_fs_pkg

// ===== clk_fail_safe.sv
`timescale 1ns/10ps
`default_nettype none
module clk_fail_safe
  import clk_fs_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [3:0] adr_i,
  input  wire logic [7:0] dat_i,
  output logic      [7:0] dat_o,
  input  wire logic       we_i,
  input  wire logic       sel_i,
  input  wire logic       cyc_i,
  input  wire logic       stb_i,
  output logic            ack_o,
  input  wire logic [2:0] reset_osc_select_i,
  input  wire logic       switch_allow_cfg_i,
  input  wire logic       ext_clock_input_mode_i,
  input  wire logic       sleep_i,
  input  wire logic       ext_clk_pin_i,
  input  wire logic       slow_osc_pin_i,
  input  wire logic [7:0] osc_ready_i,
  output logic      [2:0] current_source_o,
  output logic      [3:0] current_divider_o,
  output logic            secondary_osc_power_o,
  output logic            osc_fail_irq_o,
  output logic            switch_irq_o
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [1:0] ext_s_r;
  logic [1:0] slow_s_r;
  logic       ext_d_r;
  logic       slow_d_r;
  // two flops before anything looks at the pins
  always_ff @(posedge clk_i)
  begin
    ext_s_r  <= {ext_s_r[0], ext_clk_pin_i};
    slow_s_r <= {slow_s_r[0], slow_osc_pin_i};
    ext_d_r  <= ext_s_r[1];
    slow_d_r <= slow_s_r[1];
  end
  wire ext_fall  = ext_d_r & ~ext_s_r[1];
  wire slow_rise = ~slow_d_r & slow_s_r[1];

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [2:0] new_source_request_r;
  logic [3:0] new_divider_request_r;
  logic [2:0] current_source_r;
  logic [3:0] current_divider_r;
  logic       switch_hold_r;
  logic       secondary_osc_power_r;
  logic       osc_fail_flag_r;
  logic       osc_fail_irq_enable_r;
  logic       fail_safe_r;
  logic       ost_done_r;
  logic [10:0] ost_cnt_r;
  logic [5:0] samp_div_r;
  logic       fail_latch_r;
  logic       por_r;
  logic       fail_det;
  logic       switch_irq_r;
  sw_state_t  state_r;

  // bus strobes: single-cycle answer
  wire req_w = cyc_i & stb_i & ~ack_o;
  wire wr_w  = req_w & we_i & sel_i;
  wire wr_req  = wr_w & (adr_i == ADDR_REQ);
  wire wr_hsk  = wr_w & (adr_i == ADDR_HSK);
  wire wr_fail = wr_w & (adr_i == ADDR_FAIL);
  wire src_rsv = (dat_i[6:4] == SRC_RSV3) | (dat_i[6:4] == SRC_RSV0);
  wire req_take = wr_req & switch_allow_cfg_i & ~src_rsv;
  wire req_chg  = req_take & (dat_i[6:0] != {new_source_request_r, new_divider_request_r});

  // reserved codes act as the fast internal code
  function automatic logic [2:0] eff_src(input logic [2:0] s);
    eff_src = ((s == SRC_RSV3) || (s == SRC_RSV0)) ? SRC_FAST : s;
  endfunction : eff_src
  function automatic logic is_ext(input logic [2:0] s);
    is_ext = (s == SRC_EXT) || (s == SRC_EXTPLL);
  endfunction : is_ext
  function automatic logic needs_ost(input logic [2:0] s);
    needs_ost = is_ext(s) || (s == SRC_FSTPLL);
  endfunction : needs_ost

  // the requested oscillator's ready line, indexed by its code
  wire tgt_ready = osc_ready_i[eff_src(new_source_request_r)];
  wire pending   = {new_source_request_r, new_divider_request_r} !=
                   {current_source_r, current_divider_r};
  // a request to external waits on the startup timer as well
  wire tgt_ok    = tgt_ready & (~needs_ost(new_source_request_r) | ost_done_r);

  // ----------------------------------------
  // request register
  // ----------------------------------------
  // por_r marks the first cycle out of reset, when the strap is sampled
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      por_r <= 1'b1;
    else
      por_r <= 1'b0;
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      new_source_request_r  <= SRC_FAST;
      new_divider_request_r <= DIV_FAST_RST;
    end
    else if (por_r)
    begin
      new_source_request_r  <= reset_osc_select_i;
      new_divider_request_r <= (reset_osc_select_i == SRC_FAST) ? DIV_FAST_RST
                                                                 : DIV_RST;
    end
    else if (req_take)
    begin
      new_source_request_r  <= dat_i[6:4];
      new_divider_request_r <= dat_i[3:0];
    end
  end

  // ----------------------------------------
  // switch sequencer
  // ----------------------------------------
  // current selection follows the request only on a completed switch
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_r           <= ST_IDLE;
      current_source_r  <= SRC_FAST;
      current_divider_r <= DIV_FAST_RST;
      switch_irq_r      <= 1'b0;
    end
    else if (por_r)
    begin
      current_source_r  <= reset_osc_select_i;
      current_divider_r <= (reset_osc_select_i == SRC_FAST) ? DIV_FAST_RST : DIV_RST;
    end
    else if (fail_det)
    begin
      current_source_r  <= SRC_FAST;
      current_divider_r <= DIV_1MHZ;
      state_r           <= ST_IDLE;
      switch_irq_r      <= 1'b0;
    end
    else
    begin
      switch_irq_r <= 1'b0;
      case (state_r)
        ST_IDLE:
          if (pending && !sleep_i && !(fail_safe_r && !req_chg))
            state_r <= ST_WAIT;
        ST_WAIT:
          if (!pending || sleep_i)
            state_r <= ST_IDLE;  // abandoned, or sleep cancels it
          else if (tgt_ok)
          begin
            switch_irq_r <= 1'b1;
            if (switch_hold_r)
              state_r <= ST_HOLD;
            else
            begin
              current_source_r  <= new_source_request_r;
              current_divider_r <= new_divider_request_r;
              state_r           <= ST_IDLE;
            end
          end
        ST_HOLD:
          if (!pending || sleep_i)
            state_r <= ST_IDLE;
          else if (!switch_hold_r && tgt_ok)
          begin
            current_source_r  <= new_source_request_r;
            current_divider_r <= new_divider_request_r;
            state_r           <= ST_IDLE;
          end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // handshake bits
  // ----------------------------------------
  // hold is cleared by hardware when a held switch is abandoned (request equals current again)
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      switch_hold_r         <= 1'b0;
      secondary_osc_power_r <= 1'b0;
    end
    else
    begin
      if (wr_hsk)
        secondary_osc_power_r <= dat_i[SPWR_BIT];
      if (state_r == ST_HOLD && !pending)
        switch_hold_r <= 1'b0;
      else if (wr_hsk)
        switch_hold_r <= dat_i[HOLD_BIT];
    end
  end
  wire switch_done = ~pending;
  wire new_ready   = (state_r != ST_IDLE) & tgt_ok;

  // ----------------------------------------
  // startup timer
  // ----------------------------------------
  // restarted by reset, sleep and any switch toward an external or pll source
  wire ost_restart = sleep_i | (req_take & needs_ost(dat_i[6:4]));
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ost_cnt_r  <= 11'h000;
      ost_done_r <= 1'b0;
    end
    else if (ext_clock_input_mode_i)
      ost_done_r <= 1'b1;
    else if (ost_restart)
    begin
      ost_cnt_r  <= 11'h000;
      ost_done_r <= 1'b0;
    end
    else if (!ost_done_r)
    begin
      ost_cnt_r <= ost_cnt_r + 11'h001;
      if (ost_cnt_r == 11'(OST_CYCLES - 1))
        ost_done_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // failure monitor
  // ----------------------------------------
  // sample clock is the slow osc divided by 64, built from its edges
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      samp_div_r <= 6'h00;
    end
    else if (slow_rise)
    begin
      samp_div_r <= samp_div_r + 6'h01;
    end
  end
  wire samp_rise = slow_rise & (samp_div_r == 6'(SAMPLE_DIV - 1));
  wire samp_fall = slow_rise & (samp_div_r == 6'(SAMPLE_HALF - 1));
  // latch set on falling ext edge, cleared on rising sample edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      fail_latch_r <= 1'b0;
    else if (ext_fall)
      fail_latch_r <= 1'b1;
    else if (samp_rise)
      fail_latch_r <= 1'b0;
  end
  // only judged while running externally, timer expired, not already failed
  assign fail_det = samp_fall & ~fail_latch_r & ost_done_r & ~fail_safe_r &
                    is_ext(current_source_r) & ~por_r;

  // ----------------------------------------
  // fail-safe condition and fail flag
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      fail_safe_r <= 1'b0;
    else if (fail_det)
      fail_safe_r <= 1'b1;
    else if (sleep_i || req_chg)
      fail_safe_r <= 1'b0;
    else if (is_ext(current_source_r) && ost_done_r && !pending)
      fail_safe_r <= 1'b0;
  end
  // set wins over a same-cycle software clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      osc_fail_flag_r       <= 1'b0;
      osc_fail_irq_enable_r <= 1'b0;
    end
    else
    begin
      if (fail_det)
        osc_fail_flag_r <= 1'b1;
      else if (wr_fail && !dat_i[FFLAG_BIT])
        osc_fail_flag_r <= 1'b0;
      if (wr_fail)
        osc_fail_irq_enable_r <= dat_i[FIE_BIT];
    end
  end

  // ----------------------------------------
  // bus read and outputs
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 8'h00;
    end
    else
    begin
      ack_o <= req_w;
      dat_o <= 8'h00;
      if (req_w && !we_i)
        case (adr_i)
          ADDR_REQ:  dat_o <= {1'b0, new_source_request_r, new_divider_request_r};
          ADDR_CUR:  dat_o <= {1'b0, current_source_r, current_divider_r};
          ADDR_HSK:  dat_o <= {switch_hold_r, secondary_osc_power_r, 1'b0, switch_done,
                               new_ready, 3'h0};
          ADDR_FAIL: dat_o <= {5'h00, fail_safe_r, osc_fail_irq_enable_r, osc_fail_flag_r};
          default:   dat_o <= 8'h00;
        endcase
    end
  end
  assign current_source_o      = current_source_r;
  assign current_divider_o     = current_divider_r;
  assign secondary_osc_power_o = secondary_osc_power_r;
  assign osc_fail_irq_o        = osc_fail_flag_r & osc_fail_irq_enable_r;
  assign switch_irq_o          = switch_irq_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  fail_to_fast_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fail_det |=> (current_source_r == SRC_FAST) && osc_fail_flag_r && fail_safe_r)
    else $error("failure did not select fast osc");
  fail_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (fail_det && osc_fail_irq_enable_r && !wr_fail) |=> osc_fail_irq_o)
    else $error("fail interrupt not raised");
  reserved_drop_a: assert property (@(posedge clk_i) disable iff (rst_i || por_r)
    (wr_req && src_rsv) |=> $stable(new_source_request_r) && $stable(new_divider_request_r))
    else $error("reserved write changed request");
  locked_req_a: assert property (@(posedge clk_i) disable iff (rst_i || por_r)
    !switch_allow_cfg_i |=> $stable(new_source_request_r))
    else $error("locked request changed");
  done_bit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_r != ST_IDLE) |-> !switch_done || $past(req_take))
    else $error("switch active while done reads set");
  hold_pause_a: assert property (@(posedge clk_i) disable iff (rst_i || fail_det)
    (state_r == ST_HOLD && switch_hold_r) |=> $stable(current_source_r))
    else $error("held switch moved");
  sleep_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (sleep_i && !fail_det) |=> !fail_safe_r && (!ost_done_r || ext_clock_input_mode_i))
    else $error("sleep did not clear fail-safe");
  flag_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (osc_fail_flag_r && !wr_fail) |=> osc_fail_flag_r)
    else $error("fail flag dropped without software");
  no_early_fail_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ost_restart && !ext_clock_input_mode_i) |=> !ost_done_r && !fail_det)
    else $error("timer not restarted before judging");
  switch_update_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_r == ST_WAIT && pending && !sleep_i && tgt_ok && !switch_hold_r && !fail_det) |=>
      (current_source_r == $past(new_source_request_r)) &&
      (current_divider_r == $past(new_divider_request_r)) && !new_ready)
    else $error("completed switch did not update current");
  stay_internal_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (fail_safe_r && !req_chg && !is_ext(current_source_r)) |=> !is_ext(current_source_r))
    else $error("fail-safe left the internal source");
endmodule : clk_fail_safe
`default_nettype wire

// ===== osc_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// oscillator sources seen by the monitor
// ----------------------------------------
module osc_model
(
  input  wire logic       ext_run_i,
  output logic            ext_clk_o,
  output logic            slow_clk_o,
  output logic      [7:0] osc_ready_o
);
  wire ext_ok;

  // a crystal needs time to come up, so ready answers slowly on rise
  assign #(2000, 0) ext_ok = ext_run_i;

  initial
  begin
    ext_clk_o  = 1'b1;
    slow_clk_o = 1'b0;
  end

  // a dead oscillator stops high, so no falling edge reaches the latch
  always #150 ext_clk_o = ext_run_i ? ~ext_clk_o : 1'b1;

  // slow osc sped up to keep the sample clock short in simulation
  always #100 slow_clk_o = ~slow_clk_o;

  // ready per source code; external and its pll follow the crystal
  assign osc_ready_o = {ext_ok, 4'hf, ext_ok, 2'h3};
endmodule : osc_model
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import clk_fs_pkg::*;
;
  logic       clk_i    = 1'b0;
  logic       rst_i    = 1'b1;
  logic [3:0] adr      = 4'h0;
  logic [7:0] dat_w    = 8'h00;
  logic       we       = 1'b0;
  logic       cyc      = 1'b0;
  logic       stb      = 1'b0;
  logic [2:0] strap    = 3'h6;
  logic       allow    = 1'b1;
  logic       ecim     = 1'b0;
  logic       ext_run  = 1'b1;
  logic       sleep    = 1'b0;
  logic       irq_seen = 1'b0;
  logic       ack, ext_clk, slow_clk, spwr, fail_irq, sw_irq;
  logic [7:0] dat_r, osc_rdy, q;
  logic [2:0] cur_src;
  logic [3:0] cur_div;
  int         n_errors = 0;
  int         checked  = 0;

  always #25 clk_i = ~clk_i;

  // the switch interrupt is one cycle wide, so keep a sticky copy
  always @(posedge clk_i)
    if (sw_irq === 1'b1)
      irq_seen <= 1'b1;

  osc_model OSC (.ext_run_i(ext_run), .ext_clk_o(ext_clk), .slow_clk_o(slow_clk),
                 .osc_ready_o(osc_rdy));

  clk_fail_safe DUT (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(dat_w),
    .dat_o(dat_r), .we_i(we), .sel_i(1'b1), .cyc_i(cyc), .stb_i(stb), .ack_o(ack),
    .reset_osc_select_i(strap), .switch_allow_cfg_i(allow),
    .ext_clock_input_mode_i(ecim), .sleep_i(sleep), .ext_clk_pin_i(ext_clk),
    .slow_osc_pin_i(slow_clk), .osc_ready_i(osc_rdy), .current_source_o(cur_src),
    .current_divider_o(cur_div), .secondary_osc_power_o(spwr),
    .osc_fail_irq_o(fail_irq), .switch_irq_o(sw_irq));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic end_of_test;
    $display("checked %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // classic cycle: hold everything until ack is sampled high
  task automatic wb(input logic [3:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    adr   <= a;
    we    <= w;
    dat_w <= d;
    cyc   <= 1'b1;
    stb   <= 1'b1;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 40);
    q = dat_r;
    cyc   <= 1'b0;
    stb   <= 1'b0;
    we    <= 1'b0;
    dat_w <= ~d;
    if (n >= 40)
    begin
      chk("ack_wait", 8'h00, 8'h01);
      end_of_test();
    end
  endtask : wb

  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string nm);
    wb(a, 1'b0, 8'h00);
    chk(nm, q, exp);
  endtask : rd

  task automatic wait_cur(input logic [2:0] s, output int n);
    n = 0;
    while (cur_src !== s && n < 9000)
    begin
      @(posedge clk_i);
      n++;
    end
    chk("cur_src", {5'h0, cur_src}, {5'h0, s});
  endtask : wait_cur

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset(input logic [2:0] s, input logic [7:0] e);
    strap <= s;
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rd(ADDR_REQ, e, "req_rst");
    rd(ADDR_CUR, e, "cur_rst");
    rd(ADDR_HSK, 8'h10, "hsk_rst");
    rd(ADDR_FAIL, 8'h00, "fail_rst");
  endtask : t_reset

  task automatic t_regs;
    int n;
    rd(4'h2, 8'h00, "unmapped");
    wb(ADDR_REQ, 1'b1, 8'h35);
    rd(ADDR_REQ, 8'h62, "req_rsv3");
    wb(ADDR_REQ, 1'b1, 8'h07);
    rd(ADDR_REQ, 8'h62, "req_rsv0");
    wb(ADDR_CUR, 1'b1, 8'h7f);
    rd(ADDR_CUR, 8'h62, "cur_ro");
    wb(ADDR_REQ, 1'b1, 8'hd3);
    rd(ADDR_REQ, 8'h53, "req_b7");
    wait_cur(SRC_SLOW, n);
    chk("cur_div", {4'h0, cur_div}, 8'h03);
    rd(ADDR_HSK, 8'h10, "hsk_done");
  endtask : t_regs

  task automatic t_hold;
    int n;
    wb(ADDR_HSK, 1'b1, 8'h80);
    irq_seen <= 1'b0;
    wb(ADDR_REQ, 1'b1, 8'h60);
    repeat (20) @(posedge clk_i);
    chk("sw_irq", {7'h0, irq_seen}, 8'h01);
    rd(ADDR_HSK, 8'h88, "hsk_held");
    chk("cur_held", {5'h0, cur_src}, 8'h05);
    wb(ADDR_HSK, 1'b1, 8'h40);
    wait_cur(SRC_FAST, n);
    rd(ADDR_HSK, 8'h50, "hsk_end");
    chk("spwr", {7'h0, spwr}, 8'h01);
  endtask : t_hold

  // with the start-up timer the switch must take at least its count
  task automatic t_timer(input logic m);
    int n;
    ecim <= m;
    wb(ADDR_REQ, 1'b1, 8'h70);
    wait_cur(SRC_EXT, n);
    if (m)
      chk("fast_sw", {7'h0, n < 900}, 8'h01);
    else
      chk("slow_sw", {7'h0, n >= 1000}, 8'h01);
    wb(ADDR_REQ, 1'b1, 8'h60);
    wait_cur(SRC_FAST, n);
  endtask : t_timer

  task automatic t_fail;
    int n;
    wb(ADDR_REQ, 1'b1, 8'h70);
    wait_cur(SRC_EXT, n);
    wb(ADDR_FAIL, 1'b1, 8'h02);
    ext_run <= 1'b0;
    wait_cur(SRC_FAST, n);
    chk("fs_div", {4'h0, cur_div}, {4'h0, DIV_1MHZ});
    rd(ADDR_FAIL, 8'h07, "fail_set");
    chk("fail_irq", {7'h0, fail_irq}, 8'h01);
    ext_run <= 1'b1;
    repeat (60) @(posedge clk_i);
    chk("cur_stay", {5'h0, cur_src}, 8'h06);
    wb(ADDR_REQ, 1'b1, 8'h71);
    rd(ADDR_FAIL, 8'h03, "fs_clear");
    wait_cur(SRC_EXT, n);
    chk("back_div", {4'h0, cur_div}, 8'h01);
    rd(ADDR_FAIL, 8'h03, "flag_kept");
    wb(ADDR_FAIL, 1'b1, 8'h02);
    rd(ADDR_FAIL, 8'h02, "flag_clr");
    chk("irq_off", {7'h0, fail_irq}, 8'h00);
  endtask : t_fail

  // sleep drops the fail-safe condition, the flag stays until cleared
  task automatic t_sleep;
    int n;
    ext_run <= 1'b0;
    wait_cur(SRC_FAST, n);
    rd(ADDR_FAIL, 8'h07, "refail");
    sleep <= 1'b1;
    @(posedge clk_i);
    sleep <= 1'b0;
    rd(ADDR_FAIL, 8'h03, "sleep_fs");
    wb(ADDR_FAIL, 1'b1, 8'h02);
    ext_run <= 1'b1;
    wait_cur(SRC_EXT, n);
    ext_run <= 1'b0;
    wait_cur(SRC_FAST, n);
    rd(ADDR_FAIL, 8'h07, "fs_again");
    ext_run <= 1'b1;
  endtask : t_sleep

  task automatic t_allow;
    allow <= 1'b0;
    wb(ADDR_REQ, 1'b1, 8'h53);
    rd(ADDR_REQ, 8'h71, "req_lock");
    allow <= 1'b1;
  endtask : t_allow

  initial
  begin
    t_reset(3'h6, 8'h62);
    t_regs();
    t_hold();
    t_timer(1'b0);
    t_timer(1'b1);
    t_fail();
    t_sleep();
    t_allow();
    t_reset(3'h7, 8'h70);
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
